// *** hdl/ips_regs.vh ***
// register map, field positions and timing constants of the ignition sequencer
// Behaviour
// - Before the first trial of a demand, skip prepurge or wait 30 s, per prepurge switch.
// - Trial length is 15 s or 90 s, per trial-time switch.
// - Spark and pilot valve stay on until flame or trial end.
// - Loss of established flame restarts a trial at once, no delay.
// - No flame at trial end: spark and pilot valve off, full shutoff.
// - After failed trial wait a fixed 5 minutes, then retry.
// - Retry forever until flame or demand removed; never lock out.
// - Damper seen at first power-up stays required from then on.
`ifndef IPS_REGS_VH
`define IPS_REGS_VH
`define IPS_ADDR_CTRL    12'h000
`define IPS_ADDR_STATUS  12'h004
`define IPS_ADDR_EVENT   12'h008
`define IPS_ADDR_MASK    12'h00c
`define IPS_CTRL_PREPURGE 0
`define IPS_CTRL_LONG     1
`define IPS_CTRL_RESET    32'h00000000
`define IPS_MASK_RESET    32'h00000000
`define IPS_EV_LIGHT      0
`define IPS_EV_FAIL       1
`define IPS_EV_LOST       2
`define IPS_EV_DAMPER     3
`define IPS_CLK_HZ        36'h2faf080
`define IPS_PREPURGE_S    30
`define IPS_TRIAL_SHORT_S 15
`define IPS_TRIAL_LONG_S  90
`define IPS_RETRY_S       300
`endif

// *** hdl/ips_sequencer.v ***
// intermittent pilot ignition sequencer with ahb-lite register slave
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ips_regs.vh"
module ips_sequencer #(
  parameter [35:0] PREPURGE_CYC = `IPS_PREPURGE_S * `IPS_CLK_HZ,
  parameter [35:0] SHORT_CYC    = `IPS_TRIAL_SHORT_S * `IPS_CLK_HZ,
  parameter [35:0] LONG_CYC     = `IPS_TRIAL_LONG_S * `IPS_CLK_HZ,
  parameter [35:0] RETRY_CYC    = `IPS_RETRY_S * `IPS_CLK_HZ
)(
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // appliance pins
  input  wire        heat_demand,
  input  wire        flame_sense,
  input  wire        damper_present,
  output reg         spark_on,
  output reg         pilot_valve,
  output reg         main_valve,
  output reg         damper_fault,
  output reg         irq
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_PURGE = 3'h1;
  localparam [2:0] ST_TRIAL = 3'h2;
  localparam [2:0] ST_RUN   = 3'h3;
  localparam [2:0] ST_RETRY = 3'h4;

  // appliance pins pass one three-flop filter each
  wire       demand;
  wire       flame;
  wire       damper;
  ips_sync #(
    .INIT (1'b0)
  ) u_dem_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (heat_demand),
    .level   (demand)
  );
  ips_sync #(
    .INIT (1'b0)
  ) u_flm_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (flame_sense),
    .level   (flame)
  );
  ips_sync #(
    .INIT (1'b0)
  ) u_dmp_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (damper_present),
    .level   (damper)
  );

  // ahb address phase capture
  reg        ctrl_prepurge;
  reg        ctrl_long;
  reg [3:0]  mask;
  reg [3:0]  events;
  reg        wr_pend;
  reg        rd_pend;
  reg [11:0] addr_q;
  wire       take = hsel & hready & htrans[1];
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      addr_q    <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend <= take & hwrite;
      rd_pend <= take & ~hwrite;
      if (take)
        addr_q <= haddr;
    end
  end

  // register writes in the data phase; unmapped writes are ignored
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_prepurge <= 1'b0;
      ctrl_long     <= 1'b0;
      mask          <= 4'h0;
    end
    else if (wr_pend)
    begin
      if (addr_q == `IPS_ADDR_CTRL)
      begin
        ctrl_prepurge <= hwdata[`IPS_CTRL_PREPURGE];
        ctrl_long     <= hwdata[`IPS_CTRL_LONG];
      end
      else if (addr_q == `IPS_ADDR_MASK)
        mask <= hwdata[3:0];
    end
  end

  // sequencer state and phase timer
  reg [2:0]  state;
  reg [35:0] timer;
  reg        damper_req;
  reg        boot_seen;
  reg [2:0]  boot_cnt;
  reg [3:0]  ev_set;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state      <= ST_IDLE;
      timer      <= 36'h0;
      damper_req <= 1'b0;
      boot_seen  <= 1'b0;
      boot_cnt   <= 3'h0;
      ev_set     <= 4'h0;
    end
    else
    begin
      ev_set <= 4'h0;
      // latch damper fitting once the pin filter has settled; earlier
      // the filter still shows its reset level, not the pin
      if (boot_cnt != 3'h6)
        boot_cnt <= boot_cnt + 3'h1;
      if (boot_cnt == 3'h5)
      begin
        boot_seen  <= 1'b1;
        damper_req <= damper;
      end
      if (boot_seen && damper_req && !damper)
        ev_set[`IPS_EV_DAMPER] <= 1'b1;
      if (!demand || (damper_req && !damper))
      begin
        state <= ST_IDLE;
        timer <= 36'h0;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            if (ctrl_prepurge)
            begin
              state <= ST_PURGE;
              timer <= PREPURGE_CYC - 36'h1;
            end
            else
            begin
              state <= ST_TRIAL;
              timer <= (ctrl_long ? LONG_CYC : SHORT_CYC) - 36'h1;
            end
          end
          ST_PURGE:
          begin
            if (timer == 36'h0)
            begin
              state <= ST_TRIAL;
              timer <= (ctrl_long ? LONG_CYC : SHORT_CYC) - 36'h1;
            end
            else
              timer <= timer - 36'h1;
          end
          ST_TRIAL:
          begin
            if (flame)
            begin
              state <= ST_RUN;
              ev_set[`IPS_EV_LIGHT] <= 1'b1;
            end
            else if (timer == 36'h0)
            begin
              state <= ST_RETRY;
              timer <= RETRY_CYC - 36'h1;
              ev_set[`IPS_EV_FAIL] <= 1'b1;
            end
            else
              timer <= timer - 36'h1;
          end
          ST_RUN:
          begin
            if (!flame)
            begin
              state <= ST_TRIAL;
              timer <= (ctrl_long ? LONG_CYC : SHORT_CYC) - 36'h1;
              ev_set[`IPS_EV_LOST] <= 1'b1;
            end
          end
          ST_RETRY:
          begin
            if (timer == 36'h0)
            begin
              state <= ST_TRIAL;
              timer <= (ctrl_long ? LONG_CYC : SHORT_CYC) - 36'h1;
            end
            else
              timer <= timer - 36'h1;
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // outputs from flip-flops, one cycle behind the state (damper_fault: behind damper_req and the damper level)
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      spark_on     <= 1'b0;
      pilot_valve  <= 1'b0;
      main_valve   <= 1'b0;
      damper_fault <= 1'b0;
    end
    else
    begin
      spark_on     <= (state == ST_TRIAL);
      pilot_valve  <= (state == ST_TRIAL) || (state == ST_RUN);
      main_valve   <= (state == ST_RUN);
      damper_fault <= damper_req & ~damper;
    end
  end

  // sticky events; a read clears only the bits it reported, so an event
  // landing between address and data phase is kept; a new set wins
  wire      ev_read = rd_pend && (addr_q == `IPS_ADDR_EVENT);
  reg [3:0] next_events;
  always @*
  begin
    next_events = (events & ~(ev_read ? hrdata[3:0] : 4'h0)) | ev_set;
  end
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      events <= 4'h0;
      irq    <= 1'b0;
    end
    else
    begin
      events <= next_events;
      irq    <= |(next_events & mask);
    end
  end

  // read data, driven in the data phase; unmapped reads return zero
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (take && !hwrite)
    begin
      if (haddr == `IPS_ADDR_CTRL)
        hrdata <= {30'h0, ctrl_long, ctrl_prepurge};
      else if (haddr == `IPS_ADDR_STATUS)
        hrdata <= {24'h0, damper_req, flame, demand, 2'h0, state};
      else if (haddr == `IPS_ADDR_EVENT)
        hrdata <= {28'h0, events};
      else if (haddr == `IPS_ADDR_MASK)
        hrdata <= {28'h0, mask};
      else
        hrdata <= 32'h0;
    end
  end
endmodule

// three-flop pin filter; a change counts once stages two and three agree
module ips_sync #(
  parameter [0:0] INIT = 1'b0
)(
  // clock and reset
  input  wire hclk,
  input  wire hresetn,
  // raw pin and filtered level
  input  wire pin,
  output reg  level
);
  reg [2:0] stage;
  // only the second stage reads the first, guarding against metastability
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage <= {3{INIT}};
      level <= INIT;
    end
    else
    begin
      stage <= {stage[1:0], pin};
      if (stage[1] == stage[2])
        level <= stage[2];
    end
  end
endmodule

// *** testbench/ips_flame_model.sv ***
// far-side model of the pilot flame
`timescale 1ns/1ps
module ips_flame_model (
  // clock
  input  wire hclk,
  // gas and test control
  input  wire pilot_valve,
  input  wire light_en,
  // sensor
  output reg  flame_sense = 1'b0
);
  reg [1:0] dly = 2'h0;
  // flame needs gas for a while, dies at once without it
  always @(posedge hclk)
  begin
    dly         <= (pilot_valve && light_en) ? {dly[0], 1'b1} : 2'h0;
    flame_sense <= dly[1] && pilot_valve && light_en;
  end
endmodule

// *** testbench/ips_asserts.sv ***
// pin-level sequencing checks
`timescale 1ns/1ps
module ips_asserts #(
  parameter [35:0] SHORT_CYC = 36'ha,
  parameter [35:0] RETRY_CYC = 36'h32
)(
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // appliance pins
  input wire heat_demand,
  input wire flame_sense,
  input wire spark_on,
  input wire pilot_valve,
  input wire main_valve
);
  localparam int RMAX = RETRY_CYC + 3;
  reg [35:0] spk;
  reg [35:0] off;
  reg        failed;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // burst and gap lengths; failed marks a trial ended without flame
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      spk    <= 36'h0;
      off    <= 36'h0;
      failed <= 1'b0;
    end
    else
    begin
      spk    <= spark_on ? spk + 36'h1 : 36'h0;
      off    <= pilot_valve ? 36'h0 : off + 36'h1;
      failed <= heat_demand && !spark_on
        && (failed || (spk != 36'h0 && !main_valve));
    end
  chk_spark_pilot: assert property (spark_on |-> pilot_valve)
    else $error("spark without pilot");
  chk_lit_spark: assert property (main_valve |-> !spark_on)
    else $error("spark after lightoff");
  chk_fail_off: assert property
    ($fell(spark_on) && !main_valve |-> !pilot_valve)
    else $error("gas left on");
  chk_trial_len: assert property
    ($fell(spark_on) && !main_valve && heat_demand |-> spk >= SHORT_CYC - 1)
    else $error("trial cut short");
  chk_retry_gap: assert property
    ($rose(spark_on) && failed |->
      off >= RETRY_CYC - 1 && off <= RETRY_CYC + 2)
    else $error("retry delay wrong");
  chk_retry_again: assert property
    ($rose(failed) |-> ##[1:RMAX] (spark_on || !heat_demand))
    else $error("no retry");
  chk_flame_lost: assert property
    ($fell(flame_sense) && main_valve && heat_demand |-> ##[3:8] spark_on)
    else $error("no relight");
  chk_demand_off: assert property
    (!heat_demand [*8] |-> !pilot_valve && !spark_on && !main_valve)
    else $error("outputs on without demand");
endmodule

bind ips_sequencer ips_asserts #(
  .SHORT_CYC(SHORT_CYC),
  .RETRY_CYC(RETRY_CYC)
) u_chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .heat_demand(heat_demand),
  .flame_sense(flame_sense),
  .spark_on(spark_on),
  .pilot_valve(pilot_valve),
  .main_valve(main_valve)
);

// *** testbench/testbench.sv ***
// self-checking bench for the ignition sequencer
`timescale 1ns/1ps
`include "ips_regs.vh"
module testbench;
  // latency: filter, state, output edge, then one edge to observe it
  localparam int PURGE = 20, SHORT = 10, LONG = 30, RETRY = 50, LAT = 6;
  reg         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  reg         heat_demand = 0, light_en = 0, damper_present = 1;
  reg  [11:0] haddr = 0;
  reg  [1:0]  htrans = 0;
  reg  [31:0] hwdata = 0, q;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, flame_sense, spark_on, pilot_valve;
  wire        main_valve, damper_fault, irq;
  int         n_fail = 0, cmp_count = 0, cyc = 0, n;

  ips_sequencer #(.PREPURGE_CYC(PURGE), .SHORT_CYC(SHORT),
    .LONG_CYC(LONG), .RETRY_CYC(RETRY)) i_dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .heat_demand(heat_demand), .flame_sense(flame_sense),
    .damper_present(damper_present), .spark_on(spark_on),
    .pilot_valve(pilot_valve), .main_valve(main_valve),
    .damper_fault(damper_fault), .irq(irq));
  ips_flame_model u_far (.hclk(hclk), .pilot_valve(pilot_valve),
    .light_en(light_en), .flame_sense(flame_sense));

  always #10 hclk = ~hclk;

  task summarize;
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // exact match when t is zero, else a window of +-t cycles
  task chk(input string w, input [31:0] e, input [31:0] g, input int t);
    cmp_count++;
    if (g !== e && (t == 0 || $isunknown(g) || g > e + t || g + t < e))
    begin
      n_fail++;
      $display("wrong value %s exp %0d got %0d", w, e, g);
    end
  endtask

  // one single ahb-lite transfer, read data left in q
  task bus(input logic w, input [11:0] a, input [31:0] d);
    hsel   <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel   <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    q = hrdata;
  endtask

  // cycles until spark (0), pilot (1) or main (2) reaches v
  task wt(input int s, input logic v);
    n = 0;
    while ((s == 0 ? spark_on : s == 1 ? pilot_valve : main_valve) !== v)
    begin
      @(posedge hclk);
      n++;
    end
  endtask

  // hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      summarize;
    end
  end

  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    bus(0, `IPS_ADDR_CTRL, 0);
    chk("ctrl reset", 0, q, 0);
    chk("hresp", 0, hresp, 0);
    bus(0, 12'h010, 0);
    chk("unmapped", 0, q, 0);
    bus(1, `IPS_ADDR_MASK, 1);
    heat_demand <= 1;
    wt(0, 1); chk("no purge", LAT, n, 2);
    wt(0, 0); chk("short trial", SHORT, n, 1);
    wt(1, 1); chk("retry gap", RETRY, n, 2);
    bus(0, `IPS_ADDR_EVENT, 0); chk("fail event", 2, q, 0);
    heat_demand <= 0;
    wt(1, 0); chk("abort", LAT, n, 2);
    bus(1, `IPS_ADDR_CTRL, 3);
    bus(0, `IPS_ADDR_CTRL, 0);
    chk("ctrl rw", 3, q, 0);
    heat_demand <= 1;
    wt(0, 1); chk("purge", PURGE + LAT, n, 2);
    wt(0, 0); chk("long trial", LONG, n, 1);
    heat_demand <= 0;
    light_en    <= 1;
    bus(0, `IPS_ADDR_EVENT, 0);
    bus(1, `IPS_ADDR_CTRL, 0);
    repeat (6) @(posedge hclk);
    heat_demand <= 1;
    wt(2, 1); chk("lit spark", 0, spark_on, 0);
    repeat (2) @(posedge hclk);
    chk("irq set", 1, irq, 0);
    bus(0, `IPS_ADDR_EVENT, 0);
    chk("lit event", 1, q, 0);
    repeat (2) @(posedge hclk);
    chk("irq clear", 0, irq, 0);
    light_en <= 0;
    wt(0, 1); chk("relight", LAT + 2, n, 2);
    heat_demand <= 0;
    wt(1, 0); chk("stop", LAT, n, 2);
    damper_present <= 0;
    heat_demand    <= 1;
    repeat (8) @(posedge hclk);
    chk("damper fault", 1, damper_fault, 0);
    chk("damper gas", 0, pilot_valve, 0);
    bus(0, `IPS_ADDR_EVENT, 0); chk("damper event", 12, q, 0);
    bus(0, `IPS_ADDR_STATUS, 0); chk("status", 32'ha0, q, 0);
    summarize;
  end
endmodule
